//--- design/timer_interrupt_subsystem.v
// Contract
// - Three fixed input lines, digital or analog, feeding requests and timer.
// - Second comparator requests on both edges, first on falling only.
// - Comparators off: threshold pin is digital input and edge source.
// - Two independent 8-bit counters, each behind a 6-bit prescaler.
// - Second timer takes internal or external clock; first internal only.
// - Prescaler divides by any value 1 through 64.
// - Counter decrements per prescaler pulse from a load of 1 to 256.
// - Counter and prescaler both ending raise that timer's request.
// - Start, stop, resume, restart; single-pass or continuous reload.
// - Counters readable without disturbance; prescalers write only.
// - Second timer clock is internal clock over four or the input line.
// - Timer input acts as clock, retrigger, one-shot trigger or gate.
// - Six maskable prioritised requests: three falls, one rise, two timers.
// - Mask enables requests globally and individually.
// - Programmable priority encoder selects among pending requests.
// - Grant disables further interrupts and branches to its vector.
// - Each vector is two bytes holding a 16-bit routine address.
// - Vector pairs follow request order, bytes 0,1 up to 10,11.
// - Masked requests still latch so software can poll them.
// - HALT stops CPU clock; timers and edges run; interrupt wakes.
// - STOP halts clocks until reset; a low stop-release pin when STOP executes restarts instead.
// - Release by pin restarts at 000C keeping port mode registers.
`timescale 1ns/1ps
`include "timer_irq_defines.vh"

module timer_interrupt_subsystem
(
    // Clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // APB slave
    input wire [7:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // Input lines and comparators
    input wire analog_in_first_pin_i,
    input wire analog_in_second_pin_i,
    input wire comparator_threshold_pin_i,
    input wire first_comparator_input_i,
    input wire second_comparator_input_i,
    input wire stop_release_pin_i,
    output wire comparator_enable_o,
    output wire [2:0] port_lines_o,
    // CPU core
    input wire irq_ack_i,
    input wire irq_return_i,
    input wire halt_exec_i,
    input wire stop_exec_i,
    output wire irq_req_o,
    output wire [15:0] irq_vector_o,
    output wire cpu_clk_en_o,
    output wire osc_en_o,
    output wire stop_restart_o,
    output wire [15:0] restart_addr_o,
    output wire port_mode_keep_o
);

// ==========================================================
// Functions
// ==========================================================
function addr_hit;
    input [7:0] a;
    begin
        addr_hit = (a == `OFS_TMODE) || (a == `OFS_CNT1) ||
            (a == `OFS_PRE1) || (a == `OFS_CNT0) ||
            (a == `OFS_PRE0) || (a == `OFS_PRIO) ||
            (a == `OFS_IREQ) || (a == `OFS_IMASK) ||
            (a == `OFS_P3MODE) || (a == `OFS_P3IN) ||
            (a == `OFS_PWR);
    end
endfunction

// Rotating order: start index first, then upward, wrapping at six
function [2:0] pick;
    input [5:0] p;
    input [2:0] start;
    integer k;
    integer j;
    begin
        pick = 3'h0;
        for (k = `NUM_REQ - 1; k >= 0; k = k - 1)
        begin
            j = (start + k) % `NUM_REQ;
            if (p[j])
                pick = j[2:0];
        end
    end
endfunction

// ==========================================================
// Registers and wires
// ==========================================================
reg [7:0] tmode_q;
reg [7:0] init0_q;
reg [7:0] init1_q;
reg [7:0] pre0_q;
reg [7:0] pre1_q;
reg [2:0] prio_q;
reg [5:0] req_q;
reg [5:0] req_d;
reg [7:0] mask_q;
reg [7:0] mask_d;
reg [7:0] p3mode_q;
reg [31:0] prdata_q;
reg [31:0] rd_d;
reg [5:0] sync1_q;
reg [5:0] sync2_q;
reg [2:0] lines_q;
reg [1:0] div4_q;
reg irq_q;
reg [2:0] vec_idx_q;
reg halt_q;
reg stop_q;
reg restart_q;
reg keep_q;

wire wr_en;
wire rd_setup;
wire analog_en;
wire [2:0] lines;
wire [2:0] fall;
wire [2:0] rise;
wire [5:0] req_set;
wire [5:0] pending;
wire [2:0] sel_idx;
wire int_tick;
wire tick0;
wire tick1;
wire trig1;
wire load0;
wire load1;
wire [7:0] cnt0;
wire [7:0] cnt1;
wire act1;
wire eoc0;
wire eoc1;
wire [1:0] tin_mode;

// ==========================================================
// APB decode
// ==========================================================
// Zero wait state; unmapped addresses answer with an error
assign wr_en = psel_i && penable_i && pwrite_i && addr_hit(paddr_i);
assign rd_setup = psel_i && !penable_i && !pwrite_i;
assign pready_o = 1'b1;
assign pslverr_o = psel_i && penable_i && !addr_hit(paddr_i);
assign prdata_o = prdata_q;

always @*
begin
    rd_d = 32'h00000000;
    case (paddr_i)
        `OFS_TMODE: rd_d[7:0] = tmode_q;
        `OFS_CNT1: rd_d[7:0] = cnt1;
        `OFS_CNT0: rd_d[7:0] = cnt0;
        `OFS_IREQ: rd_d[5:0] = req_q;
        `OFS_IMASK: rd_d[7:0] = mask_q;
        `OFS_P3MODE: rd_d[7:0] = p3mode_q;
        `OFS_P3IN: rd_d[2:0] = lines;
        `OFS_PWR: rd_d[1:0] = {stop_q, halt_q};
        default: rd_d = 32'h00000000;
    endcase
end

// ==========================================================
// Input synchronisers and line selection
// ==========================================================
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        sync1_q <= 6'h3F;
        sync2_q <= 6'h3F;
        lines_q <= 3'h7;
    end
    else
    begin
        sync1_q <= {stop_release_pin_i, second_comparator_input_i,
            first_comparator_input_i, comparator_threshold_pin_i,
            analog_in_second_pin_i, analog_in_first_pin_i};
        sync2_q <= sync1_q;
        lines_q <= lines;
    end
end

assign analog_en = p3mode_q[`P3M_ANALOG];
// Analog mode routes comparator outputs onto the first two lines
assign lines[0] = analog_en ? sync2_q[3] : sync2_q[0];
assign lines[1] = analog_en ? sync2_q[4] : sync2_q[1];
assign lines[2] = sync2_q[2];
assign fall = lines_q & ~lines;
assign rise = ~lines_q & lines;
assign port_lines_o = lines;
// Comparator supply is cut in STOP
assign comparator_enable_o = analog_en && !stop_q;

// ==========================================================
// Request sources
// ==========================================================
assign req_set[0] = fall[1];
assign req_set[1] = fall[2] && !analog_en;
assign req_set[2] = fall[0];
assign req_set[3] = rise[1];
assign req_set[4] = eoc0;
assign req_set[5] = eoc1;

// ==========================================================
// Timer clocking
// ==========================================================
// Divider freezes in STOP so neither timer advances
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
        div4_q <= 2'h0;
    else if (!stop_q)
        div4_q <= div4_q + 2'h1;
end

assign int_tick = (div4_q == `INT_DIV_LAST) && !stop_q;
assign tin_mode = tmode_q[`TM_TIN_HI:`TM_TIN_LO];
assign tick0 = int_tick;
assign tick1 = pre1_q[`PRE_EXT] ? (fall[0] && !stop_q) :
    (int_tick && (tin_mode != `TIN_GATE || lines[0]));
assign trig1 = !pre1_q[`PRE_EXT] && fall[0] &&
    ((tin_mode == `TIN_RETRIG) ||
    (tin_mode == `TIN_TRIG && !act1));
assign load0 = wr_en && paddr_i == `OFS_TMODE && pwdata_i[`TM_LOAD0];
assign load1 = (wr_en && paddr_i == `OFS_TMODE && pwdata_i[`TM_LOAD1])
    || trig1;

down_timer #(
    .CNT_W(8),
    .PRE_W(6)
) u_timer_first (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick0),
    .load_i(load0),
    .run_i(tmode_q[`TM_RUN0]),
    .cont_i(pre0_q[`PRE_CONT]),
    .init_count_i(init0_q),
    .pre_div_i(pre0_q[`PRE_DIV_HI:`PRE_DIV_LO]),
    .count_o(cnt0),
    .active_o(),
    .eoc_o(eoc0)
);

down_timer #(
    .CNT_W(8),
    .PRE_W(6)
) u_timer_second (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick1),
    .load_i(load1),
    .run_i(tmode_q[`TM_RUN1]),
    .cont_i(pre1_q[`PRE_CONT]),
    .init_count_i(init1_q),
    .pre_div_i(pre1_q[`PRE_DIV_HI:`PRE_DIV_LO]),
    .count_o(cnt1),
    .active_o(act1),
    .eoc_o(eoc1)
);

// ==========================================================
// Request, mask and grant
// ==========================================================
assign pending = req_q & mask_q[5:0];
assign sel_idx = pick(pending, prio_q);

always @*
begin
    req_d = req_q;
    if (wr_en && paddr_i == `OFS_IREQ)
        req_d = pwdata_i[5:0];
    if (irq_ack_i && irq_q)
        req_d[vec_idx_q] = 1'b0;
    // A new event beats any clear in the same cycle
    req_d = req_d | req_set;
end

always @*
begin
    mask_d = mask_q;
    if (wr_en && paddr_i == `OFS_IMASK)
        mask_d = pwdata_i[7:0];
    if (irq_return_i)
        mask_d[`MASK_GLOBAL] = 1'b1;
    if (irq_ack_i && irq_q)
        mask_d[`MASK_GLOBAL] = 1'b0;
end

always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        req_q <= `RST_REQ;
        mask_q <= `RST_BYTE;
        irq_q <= 1'b0;
        vec_idx_q <= 3'h0;
    end
    else
    begin
        req_q <= req_d;
        mask_q <= mask_d;
        if (irq_ack_i && irq_q)
            irq_q <= 1'b0;
        else
        begin
            irq_q <= mask_q[`MASK_GLOBAL] && (|pending) && !stop_q;
            vec_idx_q <= sel_idx;
        end
    end
end

assign irq_req_o = irq_q;
// Vector pair index times two gives the low byte of the pair
assign irq_vector_o = {12'h000, vec_idx_q, 1'b0};

// ==========================================================
// Software registers
// ==========================================================
// Port mode survives a pin release from STOP; only reset or a bus write changes it
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        tmode_q <= `RST_BYTE;
        init0_q <= `RST_BYTE;
        init1_q <= `RST_BYTE;
        pre0_q <= `RST_BYTE;
        pre1_q <= `RST_BYTE;
        prio_q <= `RST_PRIO;
        p3mode_q <= `RST_BYTE;
        prdata_q <= 32'h00000000;
    end
    else
    begin
        if (rd_setup)
            prdata_q <= rd_d;
        if (wr_en)
        begin
            case (paddr_i)
                `OFS_TMODE: tmode_q <= pwdata_i[7:0] &
                    8'h3A;
                `OFS_CNT1: init1_q <= pwdata_i[7:0];
                `OFS_PRE1: pre1_q <= pwdata_i[7:0];
                `OFS_CNT0: init0_q <= pwdata_i[7:0];
                `OFS_PRE0: pre0_q <= pwdata_i[7:0] &
                    8'hFE;
                `OFS_PRIO: prio_q <= pwdata_i[2:0];
                `OFS_P3MODE: p3mode_q <= pwdata_i[7:0];
                default: prio_q <= prio_q;
            endcase
        end
    end
end

// ==========================================================
// HALT and STOP
// ==========================================================
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        halt_q <= 1'b0;
        stop_q <= 1'b0;
        restart_q <= 1'b0;
        keep_q <= 1'b0;
    end
    else
    begin
        restart_q <= 1'b0;
        if (irq_q)
            halt_q <= 1'b0;
        else if (halt_exec_i)
            halt_q <= 1'b1;
        if (stop_exec_i && !stop_q)
        begin
            // Synchronised pin, two cycles behind the pad, sampled when STOP executes
            if (!sync2_q[5])
            begin
                restart_q <= 1'b1;
                keep_q <= 1'b1;
            end
            else
                stop_q <= 1'b1;
        end
    end
end

assign cpu_clk_en_o = !halt_q && !stop_q;
assign osc_en_o = !stop_q;
assign stop_restart_o = restart_q;
assign restart_addr_o = `RESTART_ADDR;
assign port_mode_keep_o = keep_q;

endmodule // timer_interrupt_subsystem

//--- inc/timer_irq_defines.vh
`ifndef TIMER_IRQ_DEFINES_VH
`define TIMER_IRQ_DEFINES_VH

// ==========================================================
// Register byte offsets on the APB window
// ==========================================================
`define OFS_TMODE 8'h00
`define OFS_CNT1 8'h04
`define OFS_PRE1 8'h08
`define OFS_CNT0 8'h0C
`define OFS_PRE0 8'h10
`define OFS_PRIO 8'h14
`define OFS_IREQ 8'h18
`define OFS_IMASK 8'h1C
`define OFS_P3MODE 8'h20
`define OFS_P3IN 8'h24
`define OFS_PWR 8'h28

// ==========================================================
// Field positions
// ==========================================================
`define TM_LOAD0 0
`define TM_RUN0 1
`define TM_LOAD1 2
`define TM_RUN1 3
`define TM_TIN_LO 4
`define TM_TIN_HI 5
`define PRE_EXT 0
`define PRE_CONT 1
`define PRE_DIV_LO 2
`define PRE_DIV_HI 7
`define MASK_GLOBAL 7
`define P3M_ANALOG 1

// ==========================================================
// Timer input modes
// ==========================================================
`define TIN_CLOCK 2'h0
`define TIN_GATE 2'h1
`define TIN_TRIG 2'h2
`define TIN_RETRIG 2'h3

// ==========================================================
// Reset values and fixed figures
// ==========================================================
`define RST_BYTE 8'h00
`define RST_PRIO 3'h0
`define RST_REQ 6'h00
`define INT_DIV_LAST 2'h3
`define RESTART_ADDR 16'h000C
`define NUM_REQ 6

`endif

//--- design/down_timer.v
`timescale 1ns/1ps
`include "timer_irq_defines.vh"

module down_timer
#(
    parameter CNT_W = 8,
    parameter PRE_W = 6
)
(
    // Clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // Control
    input wire tick_i,
    input wire load_i,
    input wire run_i,
    input wire cont_i,
    input wire [CNT_W-1:0] init_count_i,
    input wire [PRE_W-1:0] pre_div_i,
    // Status
    output wire [CNT_W-1:0] count_o,
    output wire active_o,
    output wire eoc_o
);

reg [CNT_W-1:0] count_q;
reg [PRE_W-1:0] pre_q;
reg active_q;
reg eoc_q;

// ==========================================================
// Prescaler and counter
// ==========================================================
// Zero in either field stands for the full range (64 / 256)
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        count_q <= {CNT_W{1'b0}};
        pre_q <= {PRE_W{1'b0}};
        active_q <= 1'b0;
        eoc_q <= 1'b0;
    end
    else
    begin
        eoc_q <= 1'b0;
        if (load_i)
        begin
            count_q <= init_count_i;
            pre_q <= pre_div_i;
            active_q <= 1'b1;
        end
        else if (tick_i && run_i && active_q)
        begin
            if (pre_q == {{(PRE_W-1){1'b0}}, 1'b1})
            begin
                pre_q <= pre_div_i;
                if (count_q == {{(CNT_W-1){1'b0}}, 1'b1})
                begin
                    eoc_q <= 1'b1;
                    if (cont_i)
                        count_q <= init_count_i;
                    else
                    begin
                        count_q <= {CNT_W{1'b0}};
                        active_q <= 1'b0;
                    end
                end
                else
                    count_q <= count_q - 1'b1;
            end
            else
                pre_q <= pre_q - 1'b1;
        end
    end
end

assign count_o = count_q;
assign active_o = active_q;
assign eoc_o = eoc_q;

endmodule // down_timer

//--- test/timer_irq_sva.sv
`timescale 1ns/1ps
// =====
// Interrupt and power checks
module timer_irq_sva
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Bus and CPU side
    input wire logic psel_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    input wire logic halt_exec_i,
    input wire logic stop_exec_i,
    input wire logic stop_release_pin_i,
    // Watched outputs
    input wire logic irq_req_o,
    input wire logic [15:0] irq_vector_o,
    input wire logic cpu_clk_en_o,
    input wire logic osc_en_o,
    input wire logic stop_restart_o,
    input wire logic port_mode_keep_o
);
default clocking cb @(posedge clk_sys_i);
endclocking
default disable iff (!arst_n_i);
property p_vec;
    irq_req_o |-> irq_vector_o <= 16'h000A && !irq_vector_o[0];
endproperty
a_vec: assert property (p_vec)
    else $error("vector outside the table");
property p_ack_drop;
    irq_req_o && irq_ack_i |=> !irq_req_o;
endproperty
a_ack_drop: assert property (p_ack_drop)
    else $error("request stands after grant");
// Global enable stays off until the routine returns
property p_ack_mute;
    (irq_req_o && irq_ack_i) ##1 (!irq_return_i && !psel_i)[*4]
        |-> !irq_req_o;
endproperty
a_ack_mute: assert property (p_ack_mute)
    else $error("new request before return");
property p_halt;
    halt_exec_i && !irq_req_o && osc_en_o |=> !cpu_clk_en_o;
endproperty
a_halt: assert property (p_halt)
    else $error("cpu clock runs in halt");
property p_wake;
    !cpu_clk_en_o && osc_en_o && irq_req_o && !halt_exec_i
        |=> cpu_clk_en_o;
endproperty
a_wake: assert property (p_wake)
    else $error("request did not end halt");
property p_stop_pulse;
    stop_restart_o |-> $past(stop_exec_i) ##1 !stop_restart_o;
endproperty
a_stop_pulse: assert property (p_stop_pulse)
    else $error("restart pulse without stop");
property p_keep;
    stop_restart_o |=> port_mode_keep_o[*3];
endproperty
a_keep: assert property (p_keep)
    else $error("port modes not kept");
property p_stop_osc;
    stop_release_pin_i[*4] ##0 (stop_exec_i && osc_en_o)
        |=> !osc_en_o && !cpu_clk_en_o;
endproperty
a_stop_osc: assert property (p_stop_osc)
    else $error("oscillator runs in stop");
endmodule // timer_irq_sva

bind timer_interrupt_subsystem timer_irq_sva u_sva
(
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i),
    .halt_exec_i(halt_exec_i), .stop_exec_i(stop_exec_i),
    .stop_release_pin_i(stop_release_pin_i), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .cpu_clk_en_o(cpu_clk_en_o),
    .osc_en_o(osc_en_o), .stop_restart_o(stop_restart_o),
    .port_mode_keep_o(port_mode_keep_o)
);

//--- test/cpu_core_model.sv
`timescale 1ns/1ps
// =====
// CPU core: grants and returns
module cpu_core_model
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Interrupt handshake
    input wire logic irq_req_i,
    input wire logic slow_i,
    output logic irq_ack_o,
    output logic irq_return_o
);
logic [3:0] wait_q;
logic [3:0] svc_q;
always @(posedge clk_sys_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        irq_ack_o <= 1'b0;
        irq_return_o <= 1'b0;
        wait_q <= 4'h0;
        svc_q <= 4'h0;
    end
    else
    begin
        irq_ack_o <= 1'b0;
        irq_return_o <= 1'b0;
        if (svc_q != 4'h0)
        begin
            svc_q <= svc_q - 4'h1;
            irq_return_o <= (svc_q == 4'h1);
        end
        else if (irq_req_i && !irq_ack_o)
        begin
            // Slow core lets the request stand a few cycles
            wait_q <= wait_q + 4'h1;
            if (wait_q >= (slow_i ? 4'h3 : 4'h0))
            begin
                irq_ack_o <= 1'b1;
                svc_q <= 4'h8;
                wait_q <= 4'h0;
            end
        end
    end
end
endmodule // cpu_core_model

//--- test/timer_interrupt_subsystem_tb_top.sv
`timescale 1ns/1ps
module timer_interrupt_subsystem_tb_top;
// =====
// Bench signals
logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata;
logic pin1 = 1'b1, pin2 = 1'b1, pin3 = 1'b1, rel = 1'b1;
logic cmp1 = 1'b1, cmp2 = 1'b1, halt = 1'b0, stop = 1'b0, slow = 1'b0;
logic pready, pslverr, cmp_en, ack, ret, irq, cken, osc, srst, keep;
logic [2:0] lines;
logic [15:0] vec, raddr;
logic [32:0] rd_q[$];
logic [15:0] vec_q[$];
int errors = 0, checked = 0, seed, wt;
timer_interrupt_subsystem DUT
(
    .clk_sys_i(clk), .arst_n_i(arst_n), .paddr_i(paddr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .analog_in_first_pin_i(pin1), .analog_in_second_pin_i(pin2),
    .comparator_threshold_pin_i(pin3), .first_comparator_input_i(cmp1),
    .second_comparator_input_i(cmp2), .stop_release_pin_i(rel),
    .comparator_enable_o(cmp_en), .port_lines_o(lines),
    .irq_ack_i(ack), .irq_return_i(ret), .halt_exec_i(halt),
    .stop_exec_i(stop), .irq_req_o(irq), .irq_vector_o(vec),
    .cpu_clk_en_o(cken), .osc_en_o(osc), .stop_restart_o(srst),
    .restart_addr_o(raddr), .port_mode_keep_o(keep)
);
cpu_core_model cpu
(
    .clk_sys_i(clk), .arst_n_i(arst_n), .irq_req_i(irq), .slow_i(slow),
    .irq_ack_o(ack), .irq_return_o(ret)
);
initial
    forever #5 clk = ~clk;
// =====
// Compare and bus tasks
task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    checked++;
    if (g !== e)
    begin
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
    cmp(g, e);
endtask
task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
    cmp({17'h0, g}, {17'h0, e});
endtask
task automatic cmp_lvl(input logic [15:0] g, input logic [15:0] e);
    cmp({17'h0, g}, {17'h0, e});
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk);
endtask
task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
        rd_q.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
        @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
endtask
task automatic test_done;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// =====
// Result monitor
always @(posedge clk)
begin
    if (psel && pen && !pwr && pready === 1'b1)
        cmp_rd({pslverr, prdata}, rd_q.pop_front());
    if (ack === 1'b1 && irq === 1'b1)
        cmp_vec(vec, vec_q.pop_front());
end
initial
begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
end
// =====
// Main sequence
initial
begin
    seed = 83212;
    cyc(8);
    arst_n <= 1'b1;
    cyc(4);
    for (int i = 0; i < 11; i++)
        rd(8'(4 * i), (i == 9) ? 32'h7 : 32'h0);
    apb(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
    wt = $random(seed);
    wr(8'h1C, wt);
    rd(8'h1C, wt & 32'hFF);
    wr(8'h1C, 32'h0);
    pin2 <= 1'b0;
    cyc(6);
    pin3 <= 1'b0;
    cyc(6);
    pin1 <= 1'b0;
    cyc(6);
    pin2 <= 1'b1;
    cyc(12);
    cmp_lvl(16'(lines), 16'h2);
    rd(8'h18, 32'h0F);
    wr(8'h18, 32'h0);
    pin1 <= 1'b1;
    pin3 <= 1'b1;
    cyc(8);
    rd(8'h18, 32'h0);
    wr(8'h10, 32'h08);
    wr(8'h0C, 32'h03);
    wr(8'h00, 32'h03);
    cyc(8);
    rd(8'h18, 32'h0);
    cyc(50);
    rd(8'h18, 32'h10);
    rd(8'h0C, 32'h0);
    rd(8'h00, 32'h02);
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h05);
    wr(8'h04, 32'h02);
    wr(8'h00, 32'h0C);
    repeat (2)
    begin
        pin1 <= 1'b0;
        cyc(8);
        pin1 <= 1'b1;
        cyc(8);
    end
    rd(8'h18, 32'h24);
    pin1 <= 1'b0;
    cyc(6);
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h04);
    wr(8'h04, 32'h01);
    wr(8'h00, 32'h1C);
    cyc(30);
    rd(8'h18, 32'h0);
    pin1 <= 1'b1;
    cyc(20);
    rd(8'h18, 32'h20);
    // Trigger mode: a falling edge loads the idle second timer
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h28);
    pin1 <= 1'b0;
    cyc(20);
    rd(8'h18, 32'h24);
    pin1 <= 1'b1;
    cyc(4);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h0);
    for (int p = 0; p < 6; p++)
    begin
        slow <= $random(seed);
        for (int k = 0; k < 6; k++)
            vec_q.push_back(16'(2 * ((p + k) % 6)));
        wr(8'h14, p);
        wr(8'h18, 32'h3F);
        wr(8'h1C, 32'hBF);
        wt = 0;
        while (vec_q.size() != 0 && wt < 400)
        begin
            cyc(1);
            wt++;
        end
        cmp_lvl(16'(vec_q.size()), 16'h0);
        cyc(12);
    end
    halt <= 1'b1;
    cyc(1);
    halt <= 1'b0;
    cyc(2);
    cmp_lvl(16'(cken), 16'h0);
    vec_q.push_back(16'h0008);
    wr(8'h18, 32'h10);
    cyc(20);
    cmp_lvl(16'(cken), 16'h1);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h02);
    // Comparators need settling before use
    cyc(8);
    cmp_lvl(16'(cmp_en), 16'h1);
    rel <= 1'b0;
    cyc(4);
    stop <= 1'b1;
    cyc(1);
    stop <= 1'b0;
    #1;
    cmp_lvl(16'(srst), 16'h1);
    cyc(2);
    cmp_lvl(16'(keep), 16'h1);
    cmp_lvl(raddr, 16'h000C);
    rd(8'h20, 32'h02);
    rel <= 1'b1;
    cyc(4);
    stop <= 1'b1;
    cyc(1);
    stop <= 1'b0;
    cyc(2);
    cmp_lvl({cken, osc, cmp_en}, 16'h0);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(3);
    rd(8'h20, 32'h0);
    cmp_lvl({osc, keep}, 16'h2);
    test_done;
end
endmodule // timer_interrupt_subsystem_tb_top
